/* src/osdf_pkg.sv */
// Constants, opcodes and types of the OS and double-float executor.
// Assumes a 16-bit word machine with a 15-bit word address space.
package osdf_pkg;
    localparam logic [15:0] OP_CPU_TYPE = 16'h8ac0;
    localparam logic [15:0] OP_FW_REV = 16'h8ac1;
    localparam logic [15:0] OP_IDLE = 16'h8ac2;
    localparam logic [15:0] OP_SKIP = 16'h8ac3;
    localparam logic [15:0] OP_ADD = 16'h8a02;
    localparam logic [15:0] OP_SUB = 16'h8a12;
    localparam logic [15:0] OP_MUL = 16'h8a22;
    localparam logic [15:0] OP_DIV = 16'h8a32;
    localparam logic [15:0] OP_FLT32 = 16'h8a44;
    localparam logic [15:0] OP_FLT16 = 16'h8a45;
    localparam logic [15:0] OP_FIX32 = 16'h8a46;
    localparam logic [15:0] OP_FIX16 = 16'h8a47;
    // Identity values are arbitrary.
    localparam logic [15:0] CPU_TYPE_CODE = 16'h0011;
    localparam logic [15:0] FW_REV_CODE = 16'h0021;
    localparam int IND_BIT = 15;
    localparam logic [55:0] FRAC_MAX = 56'h7f_ffff_ffff_ffff;
    localparam logic [7:0] EXP_MAX_BYTE = 8'hfe;
    localparam logic signed [11:0] EXP_HI = 12'h07f;
    localparam logic signed [11:0] EXP_LO = 12'hf80;
    localparam logic signed [11:0] INT_EXP = 12'h037;
    localparam logic signed [11:0] FIX32_LIM = 12'h020;
    localparam logic signed [11:0] FIX16_LIM = 12'h010;
    localparam logic [31:0] INT32_MAX = 32'h7fff_ffff;
    localparam logic [15:0] INT16_MAX = 16'h7fff;
    typedef enum logic [3:0] {K_CPU, K_FW, K_IDLE, K_SKIP, K_ADD, K_SUB,
        K_MUL, K_DIV, K_FLT32, K_FLT16, K_FIX32, K_FIX16, K_BAD} osdf_kind_e;
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_IND, S_RD, S_CALC, S_WR,
        S_WAIT} osdf_state_e;
endpackage : osdf_pkg

/* src/osdf_exec.sv */
// Executor for the OS query/wait/skip and double-float instructions.
// Assumes a start pulse from the fetch unit and a req/ack memory port.
`timescale 1ns/100ps
`default_nettype none
module osdf_exec
    import osdf_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic [15:0] i_opcode,
    input wire logic [14:0] i_pc,
    input wire logic [15:0] i_a,
    input wire logic [15:0] i_b,
    input wire logic i_ovf,
    input wire logic i_backplane_irq_request,
    input wire logic i_mem_ack,
    input wire logic [15:0] i_mem_rdata,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [14:0] o_mem_addr,
    output logic [15:0] o_mem_wdata,
    output logic o_busy,
    output logic o_done,
    output logic o_bad,
    output logic [14:0] o_next_pc,
    output logic [15:0] o_a,
    output logic [15:0] o_b,
    output logic o_ovf
);
    osdf_state_e st, next_st;
    osdf_kind_e kind, next_kind;
    logic irq_m, irq_s;
    logic [14:0] pc, next_pc;
    logic [1:0] ai, next_ai, wc, next_wc;
    logic [14:0] adr [3], next_adr [3];
    logic [63:0] op [3], next_op [3];
    logic [63:0] res, next_res;
    logic ovf_hit, next_ovf_hit;
    logic next_mreq, next_mwe, next_done, next_bad, next_ovf;
    logic [14:0] next_maddr, next_npc;
    logic [15:0] next_mwd, next_a, next_b;
    logic [2:0] wr_cnt;

    function automatic logic [65:0] unpack(input logic [63:0] w);
        logic [56:0] f;
        f = {w[63], w[63:8]};
        unpack = {w[63], w[63] ? 57'(-f) : f, w[0], w[7:1]};
    endfunction : unpack

    function automatic logic [64:0] pack(input logic sg,
        input logic [63:0] mi, input logic signed [11:0] ei);
        logic [63:0] m;
        logic signed [11:0] e;
        logic [55:0] f;
        m = mi;
        e = ei;
        for (int i = 0; i < 9; i++)
        begin
            if (m[63:55] != 9'h000)
            begin
                m = m >> 1;
                e = e + 12'sh001;
            end
        end
        for (int i = 0; i < 55; i++)
        begin
            if (m[54] == 1'b0 && m != 64'h0)
            begin
                m = m << 1;
                e = e - 12'sh001;
            end
        end
        f = sg ? 56'(-m[55:0]) : m[55:0];
        if (m == 64'h0)
            pack = 65'h0;
        else if (e > EXP_HI)
            pack = {1'b1, sg ? 56'(-FRAC_MAX) : FRAC_MAX, EXP_MAX_BYTE};
        else if (e < EXP_LO)
            pack = {1'b1, 64'h0};
        else
            pack = {1'b0, f, e[6:0], e[7]};
    endfunction : pack

    function automatic osdf_kind_e decode(input logic [15:0] c);
        unique case (c)
            OP_CPU_TYPE: decode = K_CPU;
            OP_FW_REV: decode = K_FW;
            OP_IDLE: decode = K_IDLE;
            OP_SKIP: decode = K_SKIP;
            OP_ADD: decode = K_ADD;
            OP_SUB: decode = K_SUB;
            OP_MUL: decode = K_MUL;
            OP_DIV: decode = K_DIV;
            OP_FLT32: decode = K_FLT32;
            OP_FLT16: decode = K_FLT16;
            OP_FIX32: decode = K_FIX32;
            OP_FIX16: decode = K_FIX16;
            default: decode = K_BAD;
        endcase
    endfunction : decode

    // Float arithmetic and conversions, evaluated from the held operands.
    logic s1, s2, s0, sr, arith, acc;
    logic [56:0] m0, m1, m2, ma, mb;
    logic signed [11:0] e0, e1, e2, er;
    logic [11:0] d;
    logic [5:0] sh;
    logic signed [59:0] v1, v2, vs;
    logic [113:0] pr;
    logic [111:0] qt;
    logic [63:0] mr;
    logic [64:0] pk;
    logic [65:0] u0, u1, u2;
    logic [31:0] iv, fx;
    logic fx_ovf;
    always_comb
    begin
        u0 = unpack(op[0]);
        {s0, m0} = u0[65:8];
        e0 = {{4{op[0][0]}}, op[0][0], op[0][7:1]};
        u1 = unpack(op[1]);
        {s1, m1} = u1[65:8];
        e1 = {{4{op[1][0]}}, op[1][0], op[1][7:1]};
        u2 = unpack(op[2]);
        {s2, m2} = u2[65:8];
        e2 = {{4{op[2][0]}}, op[2][0], op[2][7:1]};
        d = (e1 >= e2) ? 12'(e1 - e2) : 12'(e2 - e1);
        sh = (d > 12'd63) ? 6'd63 : d[5:0];
        ma = (e1 >= e2) ? m1 : m1 >> sh;
        mb = (e1 >= e2) ? m2 >> sh : m2;
        v1 = s1 ? -$signed({3'b0, ma}) : $signed({3'b0, ma});
        v2 = (s2 ^ (kind == K_SUB)) ? -$signed({3'b0, mb})
            : $signed({3'b0, mb});
        vs = v1 + v2;
        pr = m1 * m2;
        qt = {m1, 55'h0} / {55'h0, m2};
        iv = 32'h0;
        sr = 1'b0;
        mr = 64'h0;
        er = INT_EXP;
        unique case (kind)
            K_ADD, K_SUB:
            begin
                sr = vs[59];
                mr = {4'h0, sr ? 60'(-vs) : 60'(vs)};
                er = (e1 >= e2) ? e1 : e2;
            end
            K_MUL:
            begin
                sr = s1 ^ s2;
                mr = {5'h0, pr[113:55]};
                er = e1 + e2;
            end
            K_DIV:
            begin
                sr = s1 ^ s2;
                mr = (m2 == 57'h0) ? 64'h0040_0000_0000_0000 : qt[63:0];
                er = (m2 == 57'h0) ? 12'h080 : 12'(e1 - e2);
            end
            K_FLT32, K_FLT16:
            begin
                iv = (kind == K_FLT32) ? {o_a, o_b}
                    : {{16{o_a[15]}}, o_a};
                sr = iv[31];
                mr = {32'h0, sr ? 32'(-iv) : iv};
            end
            default:
            begin
                sr = 1'b0;
            end
        endcase
        pk = pack(sr, mr, er);
        iv = 32'(m0 >> 6'(INT_EXP - e0));
        fx = s0 ? 32'(-iv) : iv;
        fx_ovf = 1'b0;
        if (e0 <= 12'sh000)
            fx = 32'h0;
        else if (e0 >= ((kind == K_FIX32) ? FIX32_LIM : FIX16_LIM))
        begin
            fx = (kind == K_FIX32) ? INT32_MAX : {16'h0, INT16_MAX};
            fx_ovf = 1'b1;
        end
    end

    // Sequencer: address words, indirect chains, operand reads, store.
    always_comb
    begin
        next_st = st;
        next_kind = kind;
        next_pc = pc;
        next_ai = ai;
        next_wc = wc;
        next_adr = adr;
        next_op = op;
        next_res = res;
        next_ovf_hit = ovf_hit;
        next_maddr = o_mem_addr;
        next_mwd = o_mem_wdata;
        next_done = 1'b0;
        next_bad = o_bad;
        next_npc = o_next_pc;
        next_a = o_a;
        next_b = o_b;
        next_ovf = o_ovf;
        acc = o_mem_req & i_mem_ack;
        arith = kind inside {K_ADD, K_SUB, K_MUL, K_DIV};
        unique case (st)
            S_IDLE:
            begin
                if (i_start)
                begin
                    next_kind = decode(i_opcode);
                    next_pc = i_pc;
                    next_a = i_a;
                    next_b = i_b;
                    next_ovf = i_ovf;
                    next_ovf_hit = 1'b0;
                    next_bad = 1'b0;
                    next_ai = 2'd0;
                    next_npc = 15'(i_pc + 15'd1);
                    unique case (decode(i_opcode))
                        K_CPU:
                        begin
                            next_a = CPU_TYPE_CODE;
                            next_done = 1'b1;
                        end
                        K_FW:
                        begin
                            next_a = FW_REV_CODE;
                            next_done = 1'b1;
                        end
                        K_IDLE: next_st = S_WAIT;
                        K_SKIP:
                        begin
                            // Synchronised request line (irq_s) only; masks play no part.
                            next_npc = 15'(i_pc + (irq_s ? 15'd2 : 15'd1));
                            next_done = 1'b1;
                        end
                        K_BAD:
                        begin
                            next_bad = 1'b1;
                            next_done = 1'b1;
                        end
                        default:
                        begin
                            next_st = S_ADDR;
                            next_maddr = next_npc;
                        end
                    endcase
                end
            end
            S_WAIT:
            begin
                if (irq_s)
                begin
                    next_npc = pc;
                    next_done = 1'b1;
                    next_st = S_IDLE;
                end
            end
            S_ADDR, S_IND:
            begin
                if (acc && i_mem_rdata[IND_BIT])
                begin
                    next_st = S_IND;
                    next_maddr = i_mem_rdata[14:0];
                end
                else if (acc)
                begin
                    next_adr[ai] = i_mem_rdata[14:0];
                    next_wc = 2'd0;
                    if (ai == (arith ? 2'd2 : 2'd0))
                    begin
                        next_st = (kind inside {K_FLT32, K_FLT16}) ? S_CALC
                            : S_RD;
                        next_ai = arith ? 2'd1 : 2'd0;
                        next_maddr = arith ? adr[1] : i_mem_rdata[14:0];
                    end
                    else
                    begin
                        next_st = S_ADDR;
                        next_ai = ai + 2'd1;
                        next_maddr = 15'(pc + 15'(ai) + 15'd2);
                    end
                end
            end
            S_RD:
            begin
                if (acc)
                begin
                    next_op[ai] = {op[ai][47:0], i_mem_rdata};
                    next_wc = wc + 2'd1;
                    next_maddr = o_mem_addr + 15'd1;
                    if (wc == 2'd3 && (ai == 2'd2 || !arith))
                        next_st = S_CALC;
                    else if (wc == 2'd3)
                    begin
                        next_ai = 2'd2;
                        next_maddr = adr[2];
                    end
                end
            end
            S_CALC:
            begin
                next_npc = 15'(pc + (arith ? 15'd4 : 15'd2));
                if (kind inside {K_FIX32, K_FIX16})
                begin
                    next_a = (kind == K_FIX32) ? fx[31:16] : fx[15:0];
                    next_b = (kind == K_FIX32) ? fx[15:0] : o_b;
                    next_ovf_hit = fx_ovf;
                    next_ovf = o_ovf | fx_ovf;
                    next_done = 1'b1;
                    next_st = S_IDLE;
                end
                else
                begin
                    next_res = pk[63:0];
                    next_ovf_hit = pk[64];
                    next_ovf = o_ovf | pk[64];
                    next_mwd = pk[63:48];
                    next_maddr = adr[0];
                    next_wc = 2'd0;
                    next_st = S_WR;
                end
            end
            S_WR:
            begin
                if (acc)
                begin
                    next_res = res << 16;
                    next_mwd = res[47:32];
                    next_wc = wc + 2'd1;
                    next_maddr = o_mem_addr + 15'd1;
                    if (wc == 2'd3)
                    begin
                        next_done = 1'b1;
                        next_st = S_IDLE;
                    end
                end
            end
        endcase
        next_mreq = (next_st inside {S_ADDR, S_IND, S_RD, S_WR}) && !acc;
        next_mwe = next_st == S_WR;
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st <= S_IDLE;
            kind <= K_BAD;
            pc <= 15'h0;
            ai <= 2'd0;
            wc <= 2'd0;
            adr <= '{default: 15'h0};
            op <= '{default: 64'h0};
            res <= 64'h0;
            ovf_hit <= 1'b0;
            irq_m <= 1'b0;
            irq_s <= 1'b0;
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_addr <= 15'h0;
            o_mem_wdata <= 16'h0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_bad <= 1'b0;
            o_next_pc <= 15'h0;
            o_a <= 16'h0;
            o_b <= 16'h0;
            o_ovf <= 1'b0;
        end
        else
        begin
            st <= next_st;
            kind <= next_kind;
            pc <= next_pc;
            ai <= next_ai;
            wc <= next_wc;
            adr <= next_adr;
            op <= next_op;
            res <= next_res;
            ovf_hit <= next_ovf_hit;
            irq_m <= i_backplane_irq_request;
            irq_s <= irq_m;
            o_mem_req <= next_mreq;
            o_mem_we <= next_mwe;
            o_mem_addr <= next_maddr;
            o_mem_wdata <= next_mwd;
            o_busy <= next_st != S_IDLE;
            o_done <= next_done;
            o_bad <= next_bad;
            o_next_pc <= next_npc;
            o_a <= next_a;
            o_b <= next_b;
            o_ovf <= next_ovf;
        end
    end

    // Counts stored words of the current instruction for checking.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            wr_cnt <= 3'd0;
        else if (st == S_IDLE)
            wr_cnt <= 3'd0;
        else if (o_mem_req && o_mem_we && i_mem_ack)
            wr_cnt <= wr_cnt + 3'd1;
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_wake;
        st == S_WAIT ##0 irq_s;
    endsequence
    sequence s_skip_req;
        st == S_IDLE && i_start && i_opcode == OP_SKIP && irq_s;
    endsequence
    a_cpu_type_code: assert property (o_done && kind == K_CPU |-> o_a == CPU_TYPE_CODE) else $error("type code wrong");
    a_fw_rev_code: assert property (o_done && kind == K_FW |-> o_a == FW_REV_CODE) else $error("revision wrong");
    a_idle_no_mem: assert property (st == S_WAIT |-> !o_mem_req && !o_done) else $error("memory cycle in wait");
    a_idle_wakes: assert property (s_wake |=> o_done && o_next_pc == pc && st == S_IDLE) else $error("wait not ended");
    a_skip_taken: assert property (s_skip_req |=> o_done && o_next_pc == 15'($past(i_pc) + 15'd2)) else $error("skip missed");
    a_fix32_sat: assert property (o_done && kind == K_FIX32 && ovf_hit |-> {o_a, o_b} == INT32_MAX && o_ovf) else $error("fix32 saturation");
    a_fix16_sat: assert property (o_done && kind == K_FIX16 && ovf_hit |-> o_a == INT16_MAX && o_ovf) else $error("fix16 saturation");
    a_four_word_store: assert property (o_done && (kind inside {K_ADD, K_SUB, K_MUL, K_DIV, K_FLT32, K_FLT16}) |-> wr_cnt == 3'd4) else $error("store not four words");
    a_store_address: assert property (o_mem_req && o_mem_we |-> o_mem_addr == 15'(adr[0] + 15'(wc))) else $error("store off target");
endmodule : osdf_exec
`default_nettype wire

/* test/osdf_mem_model.sv */
// Behavioural backplane memory for the executor bench.
// Assumes the req/ack port: req stands until a one-cycle ack.
`timescale 1ns/100ps
`default_nettype none
module osdf_mem_model
(
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [14:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic o_ack,
    output logic [15:0] o_rdata
);
    logic [15:0] m [0:32767];
    int delay = 0;
    int wait_cnt = 0;

    initial
    begin
        o_ack = 1'b0;
        o_rdata = 16'h0000;
    end

    // Outside an answer the data toggles so a stale word never matches.
    always @(posedge i_clk)
    begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_req && !o_ack)
        begin
            if (wait_cnt >= delay)
            begin
                wait_cnt <= 0;
                o_ack <= 1'b1;
                if (i_we)
                    m[i_addr] <= i_wdata;
                else
                    o_rdata <= m[i_addr];
            end
            else
                wait_cnt <= wait_cnt + 1;
        end
    end
endmodule : osdf_mem_model
`default_nettype wire

/* test/tb_os_and_double_float_instr.sv */
// Self-checking bench for the OS and double-float executor.
// Assumes the behavioural memory model on the executor's memory port.
`timescale 1ns/100ps
`default_nettype none
module tb_os_and_double_float_instr
    import osdf_pkg::*;
;
    logic i_sys_clk, i_sys_rst, i_start, i_ovf, i_irq;
    logic [15:0] i_opcode, i_a, i_b, mem_rdata, o_mem_wdata, o_a, o_b;
    logic [14:0] i_pc, o_mem_addr, o_next_pc;
    logic mem_ack, o_mem_req, o_mem_we, o_busy, o_done, o_ovf, o_bad;
    int bad_count = 0;
    int n_tests = 0;
    localparam logic [63:0] ONE = 64'h4000_0000_0000_0002;
    localparam logic [63:0] TWO = 64'h4000_0000_0000_0004;
    localparam logic [63:0] FOUR = 64'h4000_0000_0000_0006;
    localparam logic [63:0] THREE = 64'h6000_0000_0000_0004;
    localparam logic [63:0] HALF = 64'h4000_0000_0000_0000;
    localparam logic [63:0] BIG = 64'h4000_0000_0000_00c8;
    localparam logic [63:0] TINY = 64'h4000_0000_0000_0039;

    initial
    begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    osdf_exec dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .i_start(i_start), .i_opcode(i_opcode), .i_pc(i_pc), .i_a(i_a),
        .i_b(i_b), .i_ovf(i_ovf), .i_backplane_irq_request(i_irq),
        .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
        .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
        .o_busy(o_busy), .o_done(o_done), .o_bad(o_bad),
        .o_next_pc(o_next_pc),
        .o_a(o_a), .o_b(o_b), .o_ovf(o_ovf));

    osdf_mem_model mem (.i_clk(i_sys_clk), .i_req(o_mem_req),
        .i_we(o_mem_we), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
        .o_ack(mem_ack), .o_rdata(mem_rdata));

    task automatic give_verdict();
        if (bad_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic put64(input logic [14:0] a, input logic [63:0] v);
        for (int i = 0; i < 4; i++)
            mem.m[a + 15'(i)] = v[63 - 16 * i -: 16];
    endtask : put64

    function automatic logic [63:0] get64(input logic [14:0] a);
        logic [63:0] v;
        for (int i = 0; i < 4; i++)
            v[63 - 16 * i -: 16] = mem.m[a + 15'(i)];
        return v;
    endfunction : get64

    // Issues one instruction and waits, bounded, for its completion.
    task automatic run(input logic [15:0] op, input logic [14:0] pc);
        int k;
        i_opcode = op;
        i_pc = pc;
        i_start = 1'b1;
        @(negedge i_sys_clk);
        i_start = 1'b0;
        k = 0;
        while (o_done !== 1'b1 && k < 3000)
        begin
            @(negedge i_sys_clk);
            k++;
        end
        if (k >= 3000)
        begin
            bad_count++;
            $display("Error at %0t: no completion", $time);
            give_verdict();
        end
        @(negedge i_sys_clk);
    endtask : run

    // The augend-like operand address goes through one indirect level.
    task automatic arith(input logic [15:0] op, input logic [63:0] x,
        input logic [63:0] y, input logic [63:0] r, input logic ov);
        mem.m[15'h0101] = 16'h0200;
        mem.m[15'h0102] = 16'h8300;
        mem.m[15'h0300] = 16'h0210;
        mem.m[15'h0103] = 16'h0220;
        put64(15'h0210, x);
        put64(15'h0220, y);
        put64(15'h0200, 64'h5555_5555_5555_5555);
        run(op, 15'h0100);
        check(get64(15'h0200), r);
        check(64'(o_ovf), 64'(ov));
        check(64'(o_next_pc), 64'h0104);
    endtask : arith

    task automatic to_flt(input logic [15:0] op, input logic [15:0] a,
        input logic [15:0] b, input logic [63:0] r);
        mem.m[15'h0101] = 16'h0200;
        i_a = a;
        i_b = b;
        run(op, 15'h0100);
        check(get64(15'h0200), r);
        check(64'(o_next_pc), 64'h0102);
    endtask : to_flt

    task automatic to_int(input logic [15:0] op, input logic [63:0] x,
        input logic [15:0] ra, input logic [15:0] rb, input logic ov);
        mem.m[15'h0101] = 16'h8300;
        mem.m[15'h0300] = 16'h0210;
        put64(15'h0210, x);
        i_b = 16'h1234;
        run(op, 15'h0100);
        check(64'({o_a, o_b}), 64'({ra, rb}));
        check(64'(o_ovf), 64'(ov));
    endtask : to_int

    task automatic queries();
        i_a = 16'hffff;
        run(OP_CPU_TYPE, 15'h0010);
        check(64'(o_a), 64'(CPU_TYPE_CODE));
        check(64'(o_next_pc), 64'h0011);
        run(OP_FW_REV, 15'h0020);
        check(64'(o_a), 64'(FW_REV_CODE));
        check(64'({o_bad, o_busy}), 64'h0);
        // An unknown word is flagged and finishes in one cycle.
        run(16'h0000, 15'h0060);
        check(64'({o_bad, o_busy}), 64'h2);
        check(64'(o_next_pc), 64'h0061);
    endtask : queries

    task automatic idle_and_skip();
        run(OP_SKIP, 15'h0030);
        check(64'(o_next_pc), 64'h0031);
        fork
            run(OP_IDLE, 15'h0040);
            begin
                repeat (20)
                begin
                    @(negedge i_sys_clk);
                    check(64'({o_busy, o_mem_req, o_done}), 64'h4);
                end
                i_irq = 1'b1;
            end
        join
        check(64'(o_next_pc), 64'h0040);
        run(OP_SKIP, 15'h0050);
        check(64'(o_next_pc), 64'h0052);
        i_irq = 1'b0;
        repeat (4) @(negedge i_sys_clk);
    endtask : idle_and_skip

    initial
    begin
        i_sys_rst = 1'b1;
        i_start = 1'b0;
        i_opcode = 16'h0000;
        i_pc = 15'h0000;
        i_a = 16'h0000;
        i_b = 16'h0000;
        i_ovf = 1'b0;
        i_irq = 1'b0;
        repeat (16) @(negedge i_sys_clk);
        i_sys_rst = 1'b0;
        @(negedge i_sys_clk);
        queries();
        idle_and_skip();
        arith(OP_ADD, ONE, ONE, TWO, 1'b0);
        arith(OP_SUB, TWO, ONE, ONE, 1'b0);
        arith(OP_MUL, TWO, TWO, FOUR, 1'b0);
        mem.delay = 3;
        arith(OP_DIV, FOUR, TWO, TWO, 1'b0);
        arith(OP_MUL, BIG, BIG, {FRAC_MAX, EXP_MAX_BYTE}, 1'b1);
        mem.delay = 0;
        arith(OP_MUL, TINY, TINY, 64'h0, 1'b1);
        to_flt(OP_FLT32, 16'h0001, 16'h0000, 64'h4000_0000_0000_0022);
        to_flt(OP_FLT16, 16'h0003, 16'h0000, THREE);
        to_int(OP_FIX32, TWO, 16'h0000, 16'h0002, 1'b0);
        to_int(OP_FIX32, HALF, 16'h0000, 16'h0000, 1'b0);
        to_int(OP_FIX32, 64'hc000_0000_0000_0050, 16'h7fff, 16'hffff,
            1'b1);
        to_int(OP_FIX16, THREE, 16'h0003, 16'h1234, 1'b0);
        to_int(OP_FIX16, HALF, 16'h0000, 16'h1234, 1'b0);
        to_int(OP_FIX16, 64'h4000_0000_0000_0020, 16'h7fff, 16'h1234,
            1'b1);
        give_verdict();
    end
endmodule : tb_os_and_double_float_instr
`default_nettype wire
